// ===== src/lvpend_cfg.svh
// Register offsets, bit positions and reset values of the low-voltage block
// Functional notes
// - Bit 7 of the low-voltage register is a read-only flag set on a low-voltage event while the master enable is set.
// - Writing 1 to acknowledge bit 6 clears the low-voltage flag, and that bit always reads as zero.
// - With interrupt enable bit 5 set, an interrupt is requested while the low-voltage flag is set; otherwise software polls.
// - Write-once reset enable bit 4, with the master enable set, forces a device reset whenever the flag is 1.
// - Read/write bit 3 keeps low-voltage detection running in stop mode when 1 and stops it there when 0.
// - Write-once master enable bit 2 switches the detector on, and the other low-voltage bits except bandgap bit 0 act only while it is set.
// - A write-once bit takes only the first write after reset and ignores later writes until the next reset.
// - Bit 0 enables the bandgap reference buffer feeding the comparator's internal channel.
// - Pending bit 4 is the keypad flag AND the keypad interrupt enable.
// - Pending bit 3 is the comparator flag AND the comparator interrupt enable.
// - Pending bit 2 is the timer overflow flag AND its interrupt enable.
// - Pending bit 1 is the periodic-wakeup flag AND its interrupt enable.
// - Pending bit 0 is set only when the low-voltage flag, its interrupt enable and the master enable are all 1.
// - Every pending bit is cleared by any reset.
// - The periodic-wakeup flag sets on timeout, clears on a write of 1 to its acknowledge bit, and that bit reads zero.
`ifndef LVPEND_CFG_SVH
`define LVPEND_CFG_SVH

`define ADDR_W 4
`define OFS_LV_CTRL 4'h0
`define OFS_PENDING 4'h1
`define OFS_WAKE_CTRL 4'h2
`define OFS_IRQ_STATUS 4'h3
`define OFS_IRQ_ENABLE 4'h4
`define OFS_IRQ_CLEAR 4'h5

`define BIT_LV_FLAG 7
`define BIT_LV_ACK 6
`define BIT_LV_IRQ_EN 5
`define BIT_LV_RESET_EN 4
`define BIT_LV_STOP_EN 3
`define BIT_LV_MASTER_EN 2
`define BIT_BANDGAP_EN 0

`define BIT_WAKE_FLAG 7
`define BIT_WAKE_ACK 6
`define BIT_WAKE_IRQ_EN 4

`define BIT_PEND_KEYPAD 4
`define BIT_PEND_COMP 3
`define BIT_PEND_TIMER 2
`define BIT_PEND_WAKE 1
`define BIT_PEND_BROWNOUT 0

`define EVT_LV 0
`define EVT_WAKE 1
`define EVT_COUNT 2

`define RESET_BYTE 8'h00
`define RESET_EVT 2'h0

`endif

// ===== src/lvpend_pkg.sv
// Types shared by the low-voltage and pending-interrupt block
package lvpend_pkg;

	typedef struct packed {
		logic keypad_flag;
		logic keypad_irq_en;
		logic comparator_flag;
		logic comparator_irq_en;
		logic timer_overflow_flag;
		logic timer_overflow_irq_en;
	} periph_irq_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ===== src/low_voltage_and_irq_pending_regs.sv
// Low-voltage control/status, wake flag and interrupt-pending registers
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lvpend_cfg.svh"

module low_voltage_and_irq_pending_regs (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Analog detector and power state (asynchronous)
	input wire logic LOW_VOLTAGE_DETECT,
	input wire logic STOP_MODE,
	input wire logic WAKE_TIMEOUT,
	// Peripheral flags and enables (same clock)
	input lvpend_pkg::periph_irq_t PERIPH,
	// Outputs to core and analog
	output logic LOW_VOLTAGE_IRQ,
	output logic LOW_VOLTAGE_RESET,
	output logic DETECTOR_ON,
	output logic BANDGAP_BUFFER_ON,
	output logic [7:0] PENDING,
	output logic IRQ
);

	lvpend_pkg::reg_req_t req;
	logic [1:0] lvd_sync;
	logic [1:0] stop_sync;
	logic [1:0] wake_sync;
	logic wake_seen;
	logic low_voltage_flag;
	logic low_voltage_irq_en;
	logic low_voltage_reset_en;
	logic low_voltage_stop_en;
	logic low_voltage_master_en;
	logic bandgap_buffer_en;
	logic reset_en_written;
	logic master_en_written;
	logic periodic_wake_flag;
	logic periodic_wake_irq_en;
	logic [`EVT_COUNT-1:0] evt_status;
	logic [`EVT_COUNT-1:0] evt_enable;
	logic [`EVT_COUNT-1:0] evt_set;
	logic [7:0] next_pending;
	logic lv_ctrl_wr;
	logic wake_ctrl_wr;
	logic lv_event;
	logic lv_set;
	logic wake_set;
	logic detector_active;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign lv_ctrl_wr = req.wr && (req.addr == `OFS_LV_CTRL);
	assign wake_ctrl_wr = req.wr && (req.addr == `OFS_WAKE_CTRL);

	// Detector level and timeout are analog/slow-domain signals
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			lvd_sync <= 2'h0;
			stop_sync <= 2'h0;
			wake_sync <= 2'h0;
		end else begin
			lvd_sync <= {lvd_sync[0], LOW_VOLTAGE_DETECT};
			stop_sync <= {stop_sync[0], STOP_MODE};
			wake_sync <= {wake_sync[0], WAKE_TIMEOUT};
		end
	end

	// Detection runs while enabled, and in stop only if allowed
	assign detector_active = low_voltage_master_en &&
		(!stop_sync[1] || low_voltage_stop_en);
	assign lv_event = detector_active && lvd_sync[1];

	// Edge of the timeout level: a held timeout marks a single event
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			wake_seen <= 1'b0;
		else
			wake_seen <= wake_sync[1];
	end
	assign wake_set = wake_sync[1] && !wake_seen;

	// Low-voltage flag: set wins over an acknowledge in the same cycle
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			low_voltage_flag <= 1'b0;
		else if (lv_event)
			low_voltage_flag <= 1'b1;
		else if (lv_ctrl_wr && req.wdata[`BIT_LV_ACK])
			low_voltage_flag <= 1'b0;
	end
	assign lv_set = lv_event && !low_voltage_flag;

	// Plain read/write controls
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			low_voltage_irq_en <= 1'b0;
			low_voltage_stop_en <= 1'b0;
			bandgap_buffer_en <= 1'b0;
		end else if (lv_ctrl_wr) begin
			low_voltage_irq_en <= req.wdata[`BIT_LV_IRQ_EN];
			low_voltage_stop_en <= req.wdata[`BIT_LV_STOP_EN];
			bandgap_buffer_en <= req.wdata[`BIT_BANDGAP_EN];
		end
	end

	// Write-once bits: the first write to the low-voltage register after reset locks them
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			low_voltage_reset_en <= 1'b0;
			reset_en_written <= 1'b0;
		end else if (lv_ctrl_wr && !reset_en_written) begin
			low_voltage_reset_en <= req.wdata[`BIT_LV_RESET_EN];
			reset_en_written <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			low_voltage_master_en <= 1'b0;
			master_en_written <= 1'b0;
		end else if (lv_ctrl_wr && !master_en_written) begin
			low_voltage_master_en <= req.wdata[`BIT_LV_MASTER_EN];
			master_en_written <= 1'b1;
		end
	end

	// Periodic-wake status/control
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			periodic_wake_irq_en <= 1'b0;
		else if (wake_ctrl_wr)
			periodic_wake_irq_en <= req.wdata[`BIT_WAKE_IRQ_EN];
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			periodic_wake_flag <= 1'b0;
		else if (wake_set)
			periodic_wake_flag <= 1'b1;
		else if (wake_ctrl_wr && req.wdata[`BIT_WAKE_ACK])
			periodic_wake_flag <= 1'b0;
	end

	// Pending register is registered, so it lags its sources by one edge
	always_comb begin
		next_pending = `RESET_BYTE;
		next_pending[`BIT_PEND_KEYPAD] =
			PERIPH.keypad_flag && PERIPH.keypad_irq_en;
		next_pending[`BIT_PEND_COMP] =
			PERIPH.comparator_flag && PERIPH.comparator_irq_en;
		next_pending[`BIT_PEND_TIMER] = PERIPH.timer_overflow_flag &&
			PERIPH.timer_overflow_irq_en;
		next_pending[`BIT_PEND_WAKE] =
			periodic_wake_flag && periodic_wake_irq_en;
		next_pending[`BIT_PEND_BROWNOUT] = low_voltage_flag &&
			low_voltage_irq_en && low_voltage_master_en;
	end

	// Writes never reach this register
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			PENDING <= `RESET_BYTE;
		else
			PENDING <= next_pending;
	end

	// Core- and analog-facing outputs
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			LOW_VOLTAGE_IRQ <= 1'b0;
			LOW_VOLTAGE_RESET <= 1'b0;
			DETECTOR_ON <= 1'b0;
			BANDGAP_BUFFER_ON <= 1'b0;
		end else begin
			LOW_VOLTAGE_IRQ <= low_voltage_flag && low_voltage_irq_en &&
				low_voltage_master_en;
			LOW_VOLTAGE_RESET <= low_voltage_flag && low_voltage_reset_en &&
				low_voltage_master_en;
			DETECTOR_ON <= detector_active;
			BANDGAP_BUFFER_ON <= bandgap_buffer_en;
		end
	end

	// Sticky event status, one bit per event
	assign evt_set[`EVT_LV] = lv_set;
	assign evt_set[`EVT_WAKE] = wake_set;

	genvar i;
	generate
		for (i = 0; i < `EVT_COUNT; i = i + 1) begin : g_evt
			always_ff @(posedge SYS_CLK or posedge RESET) begin
				if (RESET)
					evt_status[i] <= 1'b0;
				else if (evt_set[i])
					evt_status[i] <= 1'b1;
				else if (req.wr && req.addr == `OFS_IRQ_CLEAR && req.wdata[i])
					evt_status[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			evt_enable <= `RESET_EVT;
		else if (req.wr && req.addr == `OFS_IRQ_ENABLE)
			evt_enable <= req.wdata[`EVT_COUNT-1:0];
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET)
			IRQ <= 1'b0;
		else
			IRQ <= |(evt_status & evt_enable);
	end

	// Read data in the cycle after the strobe; write-only bits read zero
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= `RESET_BYTE;
		end else if (req.rd) begin
			case (req.addr)
				`OFS_LV_CTRL: RDATA <= {low_voltage_flag, 1'b0,
					low_voltage_irq_en, low_voltage_reset_en,
					low_voltage_stop_en, low_voltage_master_en,
					1'b0, bandgap_buffer_en};
				`OFS_PENDING: RDATA <= PENDING;
				`OFS_WAKE_CTRL: RDATA <= {periodic_wake_flag, 1'b0, 1'b0,
					periodic_wake_irq_en, 4'h0};
				`OFS_IRQ_STATUS: RDATA <= {6'h00, evt_status};
				`OFS_IRQ_ENABLE: RDATA <= {6'h00, evt_enable};
				default: RDATA <= `RESET_BYTE;
			endcase
		end else begin
			RDATA <= `RESET_BYTE;
		end
	end

endmodule

// ===== verification/lvpend_chk.sv
// Concurrent checks on the low-voltage and pending register block
`timescale 1ns/1ps
module lvpend_chk (
	// Clock, reset and register port
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	// Sources and outputs
	input lvpend_pkg::periph_irq_t PERIPH,
	input wire logic LOW_VOLTAGE_IRQ,
	input wire logic BANDGAP_BUFFER_ON,
	input wire logic [7:0] PENDING
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	keypad_pend_a: assert property (!$past(RESET) |-> PENDING[4] ==
		$past(PERIPH.keypad_flag && PERIPH.keypad_irq_en))
		else $error("keypad pending wrong");
	comp_pend_a: assert property (!$past(RESET) |-> PENDING[3] ==
		$past(PERIPH.comparator_flag && PERIPH.comparator_irq_en))
		else $error("comparator pending wrong");
	timer_pend_a: assert property (!$past(RESET) |-> PENDING[2] ==
		$past(PERIPH.timer_overflow_flag && PERIPH.timer_overflow_irq_en))
		else $error("timer pending wrong");
	brownout_pend_a: assert property ($past(RD) && $past(ADDR) == 4'h0
		|-> PENDING[0] == (RDATA[7] && RDATA[5] && RDATA[2]) &&
		LOW_VOLTAGE_IRQ == PENDING[0])
		else $error("brownout pending differs from control bits");
	ack_reads_zero_a: assert property ($past(RD) && $past(ADDR) == 4'h0
		|-> !RDATA[6]) else $error("ack bit read as one");
	wake_ack_zero_a: assert property ($past(RD) && $past(ADDR) == 4'h2
		|-> !RDATA[6]) else $error("wake ack read as one");
	pend_image_a: assert property ($past(RD) && $past(ADDR) == 4'h1
		|-> RDATA == $past(PENDING)) else $error("pending read wrong");
	bandgap_a: assert property ($past(WR, 2) && $past(ADDR, 2) == 4'h0
		|-> BANDGAP_BUFFER_ON == $past(WDATA[0], 2))
		else $error("bandgap enable wrong");
	cover property (PENDING[0]);
	cover property ($past(RD) && $past(ADDR) == 4'h1 && RDATA != 8'h00);
	cover property (LOW_VOLTAGE_IRQ ##1 !LOW_VOLTAGE_IRQ);
endmodule

bind low_voltage_and_irq_pending_regs lvpend_chk lvpend_chk_i (.SYS_CLK,
	.RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .PERIPH, .LOW_VOLTAGE_IRQ,
	.BANDGAP_BUFFER_ON, .PENDING);

// ===== verification/lvpend_src.sv
// Peripheral interrupt sources: flags and enables settle on the clock
`timescale 1ns/1ps
module lvpend_src (
	// Clock and requested levels
	input wire logic clk,
	input wire logic [5:0] want,
	// Levels seen by the block
	output lvpend_pkg::periph_irq_t periph
);
	always_ff @(posedge clk) begin
		periph <= want;
	end
endmodule

// ===== verification/tb_low_voltage_and_irq_pending_regs.sv
// Self-checking bench for the low-voltage and pending register block
`timescale 1ns/1ps
module tb_low_voltage_and_irq_pending_regs;
	logic clk = 0, rst = 1, wr = 0, rd = 0, brownout_pending = 0, stp = 0, wto = 0;
	logic rd_seen = 0, lv_irq, lv_rst, det_on, bg_on, irq;
	logic [3:0] a = 4'h0;
	logic [7:0] d = 8'h00, rdata, pend;
	logic [5:0] want = 6'h00;
	logic [7:0] q[$];
	lvpend_pkg::periph_irq_t periph;
	int miscompares = 0, n_compared = 0;
	integer seed = 57989;
	always #2 clk = ~clk;
	lvpend_src lvpend_src_i (.clk(clk), .want(want), .periph(periph));
	low_voltage_and_irq_pending_regs low_voltage_and_irq_pending_regs_i (
		.SYS_CLK(clk), .RESET(rst), .ADDR(a), .WDATA(d), .WR(wr), .RD(rd),
		.RDATA(rdata), .LOW_VOLTAGE_DETECT(brownout_pending), .STOP_MODE(stp),
		.WAKE_TIMEOUT(wto), .PERIPH(periph), .LOW_VOLTAGE_IRQ(lv_irq),
		.LOW_VOLTAGE_RESET(lv_rst), .DETECTOR_ON(det_on),
		.BANDGAP_BUFFER_ON(bg_on), .PENDING(pend), .IRQ(irq));
	task cmp(string n, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task flag(string n, logic e, logic g);
		cmp(n, {7'h00, e}, {7'h00, g});
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task wr8(logic [3:0] ad, logic [7:0] v);
		@(posedge clk);
		a <= ad;
		d <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(logic [3:0] ad, logic [7:0] e);
		@(posedge clk);
		a <= ad;
		rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) rd_seen <= rd;
	always @(negedge clk) begin
		if (rd_seen && q.size() > 0) begin
			cmp("rdata", q.pop_front(), rdata);
		end
	end
	initial begin
		logic [5:0] r;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) rd8(i[3:0], 8'h00);
		rd8(4'hf, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 12; i++) begin
			r = 6'($random(seed));
			want <= r;
			repeat (3) @(posedge clk);
			rd8(4'h1, {3'h0, r[5] & r[4], r[3] & r[2], r[1] & r[0], 2'h0});
		end
		wr8(4'h1, 8'hff);
		rd8(4'h1, {3'h0, r[5] & r[4], r[3] & r[2], r[1] & r[0], 2'h0});
		want <= 6'h00;
		$display("test pending sources done");
		wr8(4'h0, 8'h35);
		rd8(4'h0, 8'h35);
		wr8(4'h0, 8'h28);
		rd8(4'h0, 8'h3c);
		brownout_pending <= 1'b1;
		repeat (8) @(negedge clk);
		flag("lv reset", 1'b1, lv_rst);
		flag("lv irq", 1'b1, lv_irq);
		flag("irq masked", 1'b0, irq);
		rd8(4'h0, 8'hbc);
		brownout_pending <= 1'b0;
		rd8(4'h0, 8'hbc);
		rd8(4'h1, 8'h01);
		rd8(4'h3, 8'h01);
		wr8(4'h4, 8'h03);
		repeat (3) @(negedge clk);
		flag("irq", 1'b1, irq);
		wr8(4'h5, 8'h01);
		wr8(4'h0, 8'h68);
		repeat (3) @(negedge clk);
		flag("irq cleared", 1'b0, irq);
		rd8(4'h0, 8'h3c);
		rd8(4'h1, 8'h00);
		stp <= 1'b1;
		repeat (4) @(negedge clk);
		flag("detector in stop", 1'b1, det_on);
		wr8(4'h0, 8'h20);
		repeat (4) @(negedge clk);
		flag("detector stopped", 1'b0, det_on);
		$display("test low voltage done");
		wr8(4'h2, 8'h10);
		stp <= 1'b0;
		wto <= 1'b1;
		repeat (5) @(negedge clk);
		rd8(4'h2, 8'h90);
		rd8(4'h1, 8'h02);
		rd8(4'h3, 8'h02);
		@(negedge clk);
		flag("irq wake", 1'b1, irq);
		wr8(4'h2, 8'h50);
		wr8(4'h5, 8'h02);
		rd8(4'h2, 8'h10);
		rd8(4'h1, 8'h00);
		wto <= 1'b0;
		want <= 6'h3f;
		repeat (4) @(posedge clk);
		rst <= 1'b1;
		want <= 6'h00;
		@(negedge clk);
		cmp("pending", 8'h00, pend);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd8(4'h1, 8'h00);
		for (int i = 0; i < 8 && q.size() > 0; i++) @(negedge clk);
		if (q.size() > 0) miscompares++;
		$display("test wake and reset done");
		conclude();
	end
endmodule
